// [inc/jfe_pkg.sv]
// constants, carriers and helpers for the jitter fifo and equalizer threshold block
package jfe_pkg;

   // register page and offsets on the microprocessor port
   localparam logic [2:0] REG_PAGE      = 3'h2;
   localparam logic [4:0] OFF_JA_CTRL   = 5'h13;
   localparam logic [4:0] OFF_EQ_UPPER  = 5'h16;
   localparam logic [4:0] OFF_EQ_LOWER  = 5'h17;

   // field positions in the jitter fifo control register
   localparam int         POS_DEPTH_SEL = 3;
   localparam int         POS_CLEAR     = 2;

   // reset values
   localparam logic [2:0] RST_DEPTH_SEL = 3'h0;
   localparam logic       RST_CLEAR     = 1'b0;
   localparam logic [7:0] RST_EQ_UPPER  = 8'hBB;
   localparam logic [7:0] RST_EQ_LOWER  = 8'h30;
   localparam logic [3:0] RST_EQ_LEVEL  = 4'h0;
   localparam logic [7:0] RST_RDATA     = 8'h00;

   // fifo sizing: depth is sixteen entries per code step
   localparam logic [7:0] DEPTH_STEP    = 8'h10;
   localparam int         FIFO_MAX      = 128;
   localparam int         PTR_W         = 7;

   // equalization level range
   localparam logic [3:0] EQ_LEVEL_MIN  = 4'h0;
   localparam logic [3:0] EQ_LEVEL_MAX  = 4'hF;

   // control register fields
   typedef struct packed {
      logic [2:0] depth_sel;
      logic       clear;
   } jfe_ja_ctrl_t;

   // equalizer threshold pair
   typedef struct packed {
      logic [7:0] upper;
      logic [7:0] lower;
   } jfe_eq_thr_t;

   // depth in entries for a depth select code
   function automatic logic [7:0] jfe_depth_of(input logic [2:0] code);
      return 8'(({5'h00, code} + 8'h01) * DEPTH_STEP);
   endfunction : jfe_depth_of

endpackage : jfe_pkg

// [rtl/jfe_eq_step.sv]
// automatic equalization level stepping from the peak detector count
`timescale 1ns/1ps
module jfe_eq_step
(
   // clock and reset
   input  wire logic                 i_mclk,
   input  wire logic                 i_srst,
   // mode and thresholds
   input  wire logic                 i_auto_adc,
   input  wire jfe_pkg::jfe_eq_thr_t i_thr,
   // peak detector
   input  wire logic [7:0]           i_peak_count,
   input  wire logic                 i_peak_valid,
   // equalization level
   output      logic [3:0]           o_eq_level
);

   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         o_eq_level <= jfe_pkg::RST_EQ_LEVEL;
      end
      else if (i_auto_adc && i_peak_valid)
      begin
         // unsigned compare, one step, saturating
         if (i_peak_count > i_thr.upper)
         begin
            if (o_eq_level != jfe_pkg::EQ_LEVEL_MIN)
            begin
               o_eq_level <= o_eq_level - 4'h1;
            end
         end
         else if (i_peak_count < i_thr.lower)
         begin
            if (o_eq_level != jfe_pkg::EQ_LEVEL_MAX)
            begin
               o_eq_level <= o_eq_level + 4'h1;
            end
         end
      end
   end

endmodule : jfe_eq_step

// [rtl/jfe_regs.sv]
// page 2 control registers, jitter attenuator fifo and equalizer threshold top
// Operation
// - depth select code 0..7 sizes the attenuator fifo at 16 to 128 entries.
// - while the clear bit is one, attenuator pointers and status stay reset.
// - after a clear the fifo status reports empty.
// - a clear leaves the stored fifo data bits untouched.
// - count above the upper threshold steps equalization one level lower.
// - count below the lower threshold steps equalization one level higher.
// - thresholds act only in adc based automatic equalization mode.
`timescale 1ns/1ps
module jfe_regs
(
   // clock and reset
   input  wire logic                    i_mclk,
   input  wire logic                    i_srst,
   // microprocessor port
   input  wire logic                    i_cs,
   input  wire logic                    i_wr,
   input  wire logic                    i_rd,
   input  wire logic [2:0]              i_page,
   input  wire logic [4:0]              i_addr,
   input  wire logic [7:0]              i_wdata,
   output      logic [7:0]              o_rdata,
   // attenuator fifo write side
   input  wire logic                    i_ja_wr_en,
   input  wire logic                    i_ja_wr_bit,
   output      logic                    o_ja_wr_ready,
   // attenuator fifo read side
   input  wire logic                    i_ja_rd_en,
   output      logic                    o_ja_rd_valid,
   output      logic                    o_ja_rd_bit,
   // attenuator status
   output      logic                    o_ja_empty,
   output      logic                    o_ja_full,
   output      logic [7:0]              o_ja_level,
   output      logic [7:0]              o_ja_depth,
   output      logic                    o_ja_clear,
   // equalizer
   input  wire logic                    i_eq_auto_adc,
   input  wire logic [7:0]              i_peak_count,
   input  wire logic                    i_peak_valid,
   output      logic [3:0]              o_eq_level
);

   // register state
   jfe_pkg::jfe_ja_ctrl_t ja_ctrl;
   jfe_pkg::jfe_eq_thr_t  eq_thr;

   localparam int FIFO_BITS = jfe_pkg::FIFO_MAX;

   // fifo state
   logic [FIFO_BITS-1:0]  fifo_mem;
   logic [jfe_pkg::PTR_W-1:0] wr_ptr;
   logic [jfe_pkg::PTR_W-1:0] rd_ptr;
   logic [7:0]            level;

   // decoded strobes
   logic                  sel_page;
   logic                  wr_ctrl;
   logic                  wr_upper;
   logic                  wr_lower;
   logic                  rd_any;
   logic [7:0]            next_rdata;

   // fifo handshakes
   logic [7:0]            depth;
   logic                  wr_take;
   logic                  rd_take;
   logic [jfe_pkg::PTR_W-1:0] next_wr_ptr;
   logic [jfe_pkg::PTR_W-1:0] next_rd_ptr;

   // advance a pointer, wrapping at the programmed depth
   function automatic logic [jfe_pkg::PTR_W-1:0] ptr_step(
      input logic [jfe_pkg::PTR_W-1:0] ptr,
      input logic [7:0]                dep
   );
      logic [7:0] wide;
      wide = {1'b0, ptr} + 8'h01;
      if (wide >= dep)
      begin
         return '0;
      end
      return wide[jfe_pkg::PTR_W-1:0];
   endfunction : ptr_step

   // control register readback with reserved bits as zero
   function automatic logic [7:0] ctrl_image(input jfe_pkg::jfe_ja_ctrl_t c);
      logic [7:0] img;
      img = 8'h00;
      img[jfe_pkg::POS_DEPTH_SEL +: 3] = c.depth_sel;
      img[jfe_pkg::POS_CLEAR]          = c.clear;
      return img;
   endfunction : ctrl_image

   // address decode
   always_comb
   begin
      sel_page = i_cs && (i_page == jfe_pkg::REG_PAGE);
      wr_ctrl  = sel_page && i_wr && (i_addr == jfe_pkg::OFF_JA_CTRL);
      wr_upper = sel_page && i_wr && (i_addr == jfe_pkg::OFF_EQ_UPPER);
      wr_lower = sel_page && i_wr && (i_addr == jfe_pkg::OFF_EQ_LOWER);
      rd_any   = i_cs && i_rd;
   end

   // read multiplexer, unmapped reads return zero
   always_comb
   begin
      next_rdata = 8'h00;
      if (sel_page)
      begin
         unique case (i_addr)
            jfe_pkg::OFF_JA_CTRL:  next_rdata = ctrl_image(ja_ctrl);
            jfe_pkg::OFF_EQ_UPPER: next_rdata = eq_thr.upper;
            jfe_pkg::OFF_EQ_LOWER: next_rdata = eq_thr.lower;
            default:               next_rdata = 8'h00;
         endcase
      end
   end

   // read data register
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         o_rdata <= jfe_pkg::RST_RDATA;
      end
      else if (rd_any)
      begin
         o_rdata <= next_rdata;
      end
   end

   // jitter fifo control register
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         ja_ctrl.depth_sel <= jfe_pkg::RST_DEPTH_SEL;
         ja_ctrl.clear     <= jfe_pkg::RST_CLEAR;
      end
      else if (wr_ctrl)
      begin
         ja_ctrl.depth_sel <= i_wdata[jfe_pkg::POS_DEPTH_SEL +: 3];
         ja_ctrl.clear     <= i_wdata[jfe_pkg::POS_CLEAR];
      end
   end

   // equalizer threshold registers
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         eq_thr.upper <= jfe_pkg::RST_EQ_UPPER;
         eq_thr.lower <= jfe_pkg::RST_EQ_LOWER;
      end
      else
      begin
         if (wr_upper)
         begin
            eq_thr.upper <= i_wdata;
         end
         if (wr_lower)
         begin
            eq_thr.lower <= i_wdata;
         end
      end
   end

   // fifo depth and handshakes
   always_comb
   begin
      depth         = jfe_pkg::jfe_depth_of(ja_ctrl.depth_sel);
      o_ja_empty    = (level == 8'h00);
      o_ja_full     = (level >= depth);
      o_ja_wr_ready = !o_ja_full && !ja_ctrl.clear;
      wr_take       = i_ja_wr_en && o_ja_wr_ready;
      rd_take       = i_ja_rd_en && !o_ja_empty && !ja_ctrl.clear;
      next_wr_ptr   = ptr_step(wr_ptr, depth);
      next_rd_ptr   = ptr_step(rd_ptr, depth);
   end

   // fifo storage, never reset or cleared
   always_ff @(posedge i_mclk)
   begin
      if (wr_take)
      begin
         fifo_mem[wr_ptr] <= i_ja_wr_bit;
      end
   end

   // write pointer
   always_ff @(posedge i_mclk)
   begin
      if (i_srst || ja_ctrl.clear)
      begin
         wr_ptr <= '0;
      end
      else if (wr_take)
      begin
         wr_ptr <= next_wr_ptr;
      end
   end

   // read pointer
   always_ff @(posedge i_mclk)
   begin
      if (i_srst || ja_ctrl.clear)
      begin
         rd_ptr <= '0;
      end
      else if (rd_take)
      begin
         rd_ptr <= next_rd_ptr;
      end
   end

   // fill level status
   always_ff @(posedge i_mclk)
   begin
      if (i_srst || ja_ctrl.clear)
      begin
         level <= 8'h00;
      end
      else if (wr_take && !rd_take)
      begin
         level <= level + 8'h01;
      end
      else if (rd_take && !wr_take)
      begin
         level <= level - 8'h01;
      end
   end

   // read data out
   always_ff @(posedge i_mclk)
   begin
      if (i_srst || ja_ctrl.clear)
      begin
         o_ja_rd_valid <= 1'b0;
         o_ja_rd_bit   <= 1'b0;
      end
      else
      begin
         o_ja_rd_valid <= rd_take;
         if (rd_take)
         begin
            o_ja_rd_bit <= fifo_mem[rd_ptr];
         end
      end
   end

   // status outputs
   always_comb
   begin
      o_ja_level = level;
      o_ja_depth = depth;
      o_ja_clear = ja_ctrl.clear;
   end

   // automatic equalization stepping
   jfe_eq_step u_eq_step
   (
      .i_mclk       (i_mclk),
      .i_srst       (i_srst),
      .i_auto_adc   (i_eq_auto_adc),
      .i_thr        (eq_thr),
      .i_peak_count (i_peak_count),
      .i_peak_valid (i_peak_valid),
      .o_eq_level   (o_eq_level)
   );

endmodule : jfe_regs

// [verification/jfe_regs_chk.sv]
// assertion checker for the jitter fifo and equalizer threshold registers
`timescale 1ns/1ps
module jfe_regs_chk
(
   // clock, reset and port
   input wire logic       i_mclk,
   input wire logic       i_srst,
   input wire logic       i_cs,
   input wire logic       i_wr,
   input wire logic [2:0] i_page,
   input wire logic [4:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_eq_auto_adc,
   input wire logic [7:0] i_peak_count,
   input wire logic       i_peak_valid,
   // watched outputs
   input wire logic [3:0] o_eq_level,
   input wire logic       o_ja_clear,
   input wire logic       o_ja_empty,
   input wire logic [7:0] o_ja_level,
   input wire logic       o_ja_rd_valid,
   input wire logic       o_ja_wr_ready,
   input wire logic [7:0] o_ja_depth
);
   logic [7:0] up;
   logic [7:0] lo;
   logic [2:0] wsel;
   logic       wh;
   logic       dn;
   logic       ux;
   assign wsel = i_wdata[5:3];
   assign wh = i_cs && i_wr && i_page == jfe_pkg::REG_PAGE;
   assign dn = i_peak_valid && i_eq_auto_adc && i_peak_count > up;
   assign ux = i_peak_valid && i_eq_auto_adc && i_peak_count <= up && i_peak_count < lo;
   // shadow copies of the thresholds
   always_ff @(posedge i_mclk)
      if (i_srst)
         up <= jfe_pkg::RST_EQ_UPPER;
      else if (wh && i_addr == jfe_pkg::OFF_EQ_UPPER)
         up <= i_wdata;
   always_ff @(posedge i_mclk)
      if (i_srst)
         lo <= jfe_pkg::RST_EQ_LOWER;
      else if (wh && i_addr == jfe_pkg::OFF_EQ_LOWER)
         lo <= i_wdata;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_srst);
   chk_depth_decode: assert property (wh && i_addr == jfe_pkg::OFF_JA_CTRL |=>
      o_ja_depth == {4'({1'b0, $past(wsel)} + 4'h1), 4'h0}) else $error("depth decode wrong");
   chk_clear_set: assert property (wh && i_addr == jfe_pkg::OFF_JA_CTRL && i_wdata[2] |=>
      o_ja_clear) else $error("clear bit not taken");
   chk_clear_holds: assert property (o_ja_clear |-> !o_ja_wr_ready ##1 (o_ja_empty
      && o_ja_level == 8'h00 && !o_ja_rd_valid)) else $error("fifo not held while clearing");
   chk_clear_empty: assert property ($fell(o_ja_clear) |-> o_ja_empty)
      else $error("fifo not empty after clear");
   chk_eq_down: assert property (dn && o_eq_level != 4'h0 |=>
      o_eq_level == $past(o_eq_level) - 4'h1) else $error("no step down");
   chk_eq_up: assert property (ux && o_eq_level != 4'hF |=>
      o_eq_level == $past(o_eq_level) + 4'h1) else $error("no step up");
   chk_eq_ignore: assert property (!(i_peak_valid && i_eq_auto_adc) |=>
      $stable(o_eq_level)) else $error("level moved outside auto mode");
   chk_eq_saturate: assert property ((dn && o_eq_level == 4'h0) ||
      (ux && o_eq_level == 4'hF) |=> $stable(o_eq_level)) else $error("level not saturated");
   cover property (o_ja_clear);
   cover property (dn ##1 o_eq_level == 4'h0);
   cover property (ux ##1 o_eq_level == 4'hF);
endmodule : jfe_regs_chk

bind jfe_regs jfe_regs_chk u_chk (.i_mclk, .i_srst, .i_cs, .i_wr, .i_page, .i_addr, .i_wdata,
   .i_eq_auto_adc, .i_peak_count, .i_peak_valid, .o_eq_level, .o_ja_clear, .o_ja_empty,
   .o_ja_level, .o_ja_rd_valid, .o_ja_wr_ready, .o_ja_depth);

// [verification/tb_top.sv]
// self-checking bench for the jitter fifo and equalizer threshold registers
`timescale 1ns/1ps
module tb_top;
   localparam logic [4:0] CT = jfe_pkg::OFF_JA_CTRL;
   logic i_mclk = 1'b0, i_srst = 1'b1, i_cs = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic [2:0] i_page = 3'h0;
   logic [4:0] i_addr = 5'h00;
   logic [7:0] i_wdata = 8'h00, o_rdata, o_ja_level, o_ja_depth, i_peak_count = 8'h00;
   logic i_ja_wr_en = 1'b0, i_ja_wr_bit = 1'b0, i_ja_rd_en = 1'b0, i_eq_auto_adc = 1'b0;
   logic i_peak_valid = 1'b0, o_ja_wr_ready, o_ja_rd_valid, o_ja_rd_bit;
   logic o_ja_empty, o_ja_full, o_ja_clear, rs = 1'b0, ps = 1'b0;
   logic [3:0] o_eq_level, lvl;
   logic [7:0] up, lo, cnt, rq[$], eq[$];
   int bad_count = 0, comparisons = 0, cycles = 0;
   jfe_regs uut (.i_mclk, .i_srst, .i_cs, .i_wr, .i_rd, .i_page, .i_addr, .i_wdata, .o_rdata,
      .i_ja_wr_en, .i_ja_wr_bit, .o_ja_wr_ready, .i_ja_rd_en, .o_ja_rd_valid, .o_ja_rd_bit,
      .o_ja_empty, .o_ja_full, .o_ja_level, .o_ja_depth, .o_ja_clear, .i_eq_auto_adc,
      .i_peak_count, .i_peak_valid, .o_eq_level);
   initial forever #2 i_mclk = ~i_mclk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   // one port access; a read notes its expected data
   task automatic acc(input logic w, input logic [2:0] pg, input logic [4:0] a,
      input logic [7:0] d);
      @(negedge i_mclk);
      {i_cs, i_wr, i_rd, i_page, i_addr, i_wdata} = {1'b1, w, !w, pg, a, d};
      if (!w)
         rq.push_back(d);
      @(negedge i_mclk);
      {i_cs, i_wr, i_rd} = 3'h0;
   endtask : acc
   always @(posedge i_mclk)
   begin
      rs <= i_cs && i_rd && !i_srst;
      ps <= i_peak_valid && !i_srst;
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         bad_count++;
         conclude();
      end
   end
   always @(negedge i_mclk)
   begin
      if (rs)
         chk(o_rdata, rq.pop_front());
      if (ps)
         chk({4'h0, o_eq_level}, eq.pop_front());
   end
   initial
   begin
      void'($urandom(32'h84A0));
      repeat (20) @(negedge i_mclk);
      i_srst = 1'b0;
      acc(0, 3'h2, CT, 8'h00);
      acc(0, 3'h2, jfe_pkg::OFF_EQ_UPPER, 8'hBB);
      acc(0, 3'h2, 5'h14, 8'h00);
      acc(1, 3'h1, jfe_pkg::OFF_EQ_LOWER, 8'h55);
      acc(0, 3'h2, jfe_pkg::OFF_EQ_LOWER, 8'h30);
      for (int c = 0; c < 8; c++)
      begin
         acc(1, 3'h2, CT, {2'h0, 3'(c), 3'h0});
         chk(o_ja_depth, 8'((c + 1) * 16));
      end
      {i_ja_wr_bit, i_ja_wr_en} = 2'h3;
      repeat (5) @(negedge i_mclk);
      i_ja_wr_en = 1'b0;
      acc(1, 3'h2, CT, 8'h3C);
      i_ja_wr_en = 1'b1;
      @(negedge i_mclk);
      chk({o_ja_empty, o_ja_wr_ready, o_ja_level[5:0]}, 8'h80);
      chk({o_ja_clear, 2'h0, uut.fifo_mem[4:0]}, 8'h9F);
      i_ja_wr_en = 1'b0;
      acc(1, 3'h2, CT, 8'h00);
      i_ja_wr_en = 1'b1;
      for (int i = 0; i < 20; i++)
      begin
         i_ja_wr_bit = i[0];
         @(negedge i_mclk);
      end
      i_ja_wr_en = 1'b0;
      chk({o_ja_full, o_ja_level[6:0]}, 8'h90);
      i_ja_rd_en = 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         @(negedge i_mclk);
         chk({o_ja_rd_valid, 6'h00, o_ja_rd_bit}, {7'h40, i[0]});
      end
      @(negedge i_mclk);
      chk({o_ja_empty, o_ja_rd_valid, 6'h00}, 8'h80);
      i_ja_rd_en = 1'b0;
      up = 8'h80 | 8'($urandom);
      lo = 8'h01 | (8'h7F & 8'($urandom));
      acc(1, 3'h2, jfe_pkg::OFF_EQ_UPPER, up);
      acc(1, 3'h2, jfe_pkg::OFF_EQ_LOWER, lo);
      lvl = 4'h0;
      for (int i = 0; i < 100; i++)
      begin
         cnt = (i < 20) ? 8'h00 : (i >= 60 && i < 80) ? 8'hFF : 8'($urandom);
         {i_eq_auto_adc, i_peak_count, i_peak_valid} = {i < 80, cnt, 1'b1};
         if (i < 80 && cnt > up && lvl != 4'h0)
            lvl = lvl - 4'h1;
         else if (i < 80 && cnt <= up && cnt < lo && lvl != 4'hF)
            lvl = lvl + 4'h1;
         eq.push_back({4'h0, lvl});
         @(negedge i_mclk);
      end
      i_peak_valid = 1'b0;
      @(negedge i_mclk);
      conclude();
   end
endmodule : tb_top
